// ===== zdb_pkg.sv
// Constants shared by the output divider and freeze logic
package zdb_pkg;

    // ------------------------------------------------------------
    // Divider ratio tables, index = select code, halve select high
    // ------------------------------------------------------------
    localparam int RATIO_W = 4;
    localparam logic [15:0] BANK_A_RATIOS = 16'hC462;
    localparam logic [15:0] BANK_B_RATIOS = 16'hA462;
    localparam logic [15:0] BANK_C_RATIOS = 16'h4628;
    localparam logic [15:0] FEEDBACK_RATIOS = 16'hA864;
    localparam logic [RATIO_W-1:0] RESET_RATIO = 4'h2;

    // ------------------------------------------------------------
    // Freeze register layout
    // ------------------------------------------------------------
    localparam int FREEZE_BITS = 12;
    localparam int FRZ_A_LSB = 0;
    localparam int FRZ_B_LSB = 4;
    localparam int FRZ_C_LSB = 8;
    localparam int FRZ_PULSE = 11;
    localparam logic [11:0] FREEZE_RESET = 12'hFFF;
    localparam logic [3:0] LAST_BIT = 4'hB;

    // ------------------------------------------------------------
    // Serial receiver states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_SHIFT = 2'h1,
        RX_COMMIT = 2'h3
    } zdb_rx_state_t;

endpackage

// ===== zdb_bank_divider.sv
// One bank divider: counter, held ratio and output level
`timescale 1ns/1ps
`default_nettype none

module zdb_bank_divider #(
    parameter int RATIO_W = 4,
    parameter logic [RATIO_W-1:0] RESET_RATIO = 4'h2
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic clear,
    input wire logic tick,
    input wire logic loadNow,
    input wire logic [RATIO_W-1:0] nextRatio,
    output logic [RATIO_W-1:0] count,
    output logic [RATIO_W-1:0] ratio,
    output logic wrap,
    output logic level
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (RATIO_W < 2 || RESET_RATIO < 2 || RESET_RATIO[0])
    begin : g_bad
        $error("zdb_bank_divider: width or reset ratio unusable");
    end

    // ------------------------------------------------------------
    // Counter and ratio
    // ------------------------------------------------------------
    assign wrap = tick && (count == ratio - RATIO_W'(1));
    assign level = count < {1'b0, ratio[RATIO_W-1:1]};

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            count <= '0;
        else if (clkEn)
        begin
            if (clear || wrap)
                count <= '0;
            else if (tick)
                count <= count + RATIO_W'(1);
        end
    end

    // [RQ5] Ratio swaps at boundary
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            ratio <= RESET_RATIO;
        else if (clkEn)
        begin
            if (clear || (wrap && loadNow))
                ratio <= nextRatio;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_count_range;
        @(posedge ref_clk) disable iff (!reset_n)
        count < ratio;
    endproperty
    // [RQ5] Count within period
    a_count_range: assert property (p_count_range) // [RQ5]
        else $error("divider count beyond ratio");

endmodule

`default_nettype wire

// ===== zdb_output_gen.sv
// Output dividers, coincidence pulse and serial freeze control
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RQ1] Halve high: bank A divides 2,6,4,12; bank B 2,6,4,10 for codes 0-3.
// [RQ2] Halve high: bank C divides 8,2,6,4 for codes 0-3.
// [RQ3] Halve low adds divide-by-two ahead of all banks, keeping relationships.
// [RQ4] Invert input high inverts bank C outputs 2 and 3.
// [RQ5] Select changes never give runt or stretched output periods.
// [RQ6] Coincidence pulse low one period, one period before coincident rising edges.
// [RQ7] That period is the faster of bank A and bank C.
// [RQ8] Pulse produced for every bank A and bank C ratio pair.
// [RQ9] Frozen outputs held low.
// [RQ10] Freeze register holds twelve enable bits for twelve of fourteen outputs.
// [RQ11] Bank C output 0 and feedback output never frozen.
// [RQ12] Freeze bit 0 stops output, 1 lets it run.
// [RQ13] Freeze and unfreeze only at output period boundaries.
// [RQ14] Controller sends start bit 0 then twelve freeze bits.
// [RQ15] Controller holds each data bit one serial clock period.
// [RQ16] Serial data sampled on serial clock rising edge.
// [RQ17] Bits 0-3 bank A, 4-7 bank B, 8-10 bank C 1-3, 11 pulse.
// [RQ18] Master reset pin low clears state and disables outputs.
// [RQ19] PLL use low bypasses PLL; selected reference drives dividers.
// [RQ20] Primary select low picks test reference one or two by pick input.
// [RQ21] New freeze bits apply only after all twelve bits arrive.
// [RQ22] Reset leaves all outputs enabled and receiver waiting for start bit.
module zdb_output_gen (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic master_reset_output_enable,
    input wire logic pll_use,
    input wire logic primary_source_select,
    input wire logic primary_reference,
    input wire logic first_test_reference,
    input wire logic second_test_reference,
    input wire logic test_clock_pick,
    input wire logic vco_halve_select,
    input wire logic [1:0] bank_a_ratio_select,
    input wire logic [1:0] bank_b_ratio_select,
    input wire logic [1:0] bank_c_ratio_select,
    input wire logic [2:0] feedback_ratio_select,
    input wire logic bank_c_upper_invert,
    input wire logic serial_freeze_clock,
    input wire logic serial_freeze_data,
    output logic [3:0] bank_a_clock_outputs,
    output logic [3:0] bank_b_clock_outputs,
    output logic [3:0] bank_c_clock_outputs,
    output logic feedback_clock_out,
    output logic coincidencePulse_n,
    output logic outputsEnabled
);

    localparam int W = zdb_pkg::RATIO_W;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [19:0] pinMeta;
    logic [19:0] pinSync;
    logic holdReset, pllUse, primSel, primRef, testRef0, testRef1, testPick, halveSel;
    logic [1:0] codeA, codeB, codeC;
    logic [2:0] selFb;
    logic invert, serClk, serData;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pinMeta <= '0;
            pinSync <= '0;
        end
        else if (clkEn)
        begin
            pinMeta <= {master_reset_output_enable, pll_use, primary_source_select,
                        primary_reference, first_test_reference, second_test_reference,
                        test_clock_pick, vco_halve_select, bank_a_ratio_select,
                        bank_b_ratio_select, bank_c_ratio_select, feedback_ratio_select,
                        bank_c_upper_invert, serial_freeze_clock, serial_freeze_data};
            pinSync <= pinMeta;
        end
    end

    // [RQ18] Pin low holds reset
    assign holdReset = !pinSync[19];
    assign {pllUse, primSel, primRef, testRef0, testRef1, testPick, halveSel} = pinSync[18:12];
    assign {codeA, codeB, codeC, selFb, invert, serClk, serData} = pinSync[11:0];

    // ------------------------------------------------------------
    // Reference selection and prescaler
    // ------------------------------------------------------------
    logic refSel, refPrev, baseTick, presc, halveActive, tick, boundary;

    // [RQ20] Test reference pick
    assign refSel = primSel ? primRef : (testPick ? testRef1 : testRef0);
    // [RQ19] Bypass ticks on reference edges
    assign baseTick = clkEn && (pllUse || (refSel && !refPrev));
    // [RQ3] Extra halving stage
    assign tick = baseTick && (halveActive || presc);

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            refPrev <= 1'b0;
            presc <= 1'b0;
            halveActive <= 1'b1;
        end
        else if (clkEn)
        begin
            refPrev <= refSel;
            if (holdReset || boundary)
            begin
                presc <= 1'b0;
                halveActive <= halveSel;
            end
            else if (baseTick && !halveActive)
                presc <= !presc;
        end
    end

    // ------------------------------------------------------------
    // Bank dividers
    // ------------------------------------------------------------
    logic [W-1:0] nextA, nextB, nextC, nextFb;
    logic [W-1:0] countA, countC, ratioA, ratioC;
    logic wrapA, wrapB, wrapC, levelA, levelB, levelC, levelFb;

    // [RQ1] Bank A and B tables
    assign nextA = zdb_pkg::BANK_A_RATIOS[{codeA, 2'b00} +: 4];
    assign nextB = zdb_pkg::BANK_B_RATIOS[{codeB, 2'b00} +: 4];
    // [RQ2] Bank C table
    assign nextC = zdb_pkg::BANK_C_RATIOS[{codeC, 2'b00} +: 4];
    assign nextFb = zdb_pkg::FEEDBACK_RATIOS[{selFb[1:0], 2'b00} +: 4];
    // [RQ5] Common boundary of banks A, B and C
    assign boundary = wrapA && wrapB && wrapC;

    zdb_bank_divider #(.RATIO_W(W), .RESET_RATIO(zdb_pkg::RESET_RATIO)) u_divA (
        .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn), .clear(holdReset),
        .tick(tick), .loadNow(boundary), .nextRatio(nextA), .count(countA),
        .ratio(ratioA), .wrap(wrapA), .level(levelA));
    zdb_bank_divider #(.RATIO_W(W), .RESET_RATIO(zdb_pkg::RESET_RATIO)) u_divB (
        .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn), .clear(holdReset),
        .tick(tick), .loadNow(boundary), .nextRatio(nextB), .count(),
        .ratio(), .wrap(wrapB), .level(levelB));
    zdb_bank_divider #(.RATIO_W(W), .RESET_RATIO(zdb_pkg::RESET_RATIO)) u_divC (
        .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn), .clear(holdReset),
        .tick(tick), .loadNow(boundary), .nextRatio(nextC), .count(countC),
        .ratio(ratioC), .wrap(wrapC), .level(levelC));
    zdb_bank_divider #(.RATIO_W(W), .RESET_RATIO(zdb_pkg::RESET_RATIO)) u_divFb (
        .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn), .clear(holdReset),
        .tick(tick), .loadNow(1'b1), .nextRatio(nextFb), .count(),
        .ratio(), .wrap(), .level(levelFb));

    // ------------------------------------------------------------
    // Coincidence pulse
    // ------------------------------------------------------------
    logic [W-1:0] effA, effC, fastRatio, slowRatio, slowCount, slowNext;
    logic aFast, fastWrap, leadHit, pulseLow;

    assign effA = boundary ? nextA : ratioA;
    assign effC = boundary ? nextC : ratioC;
    // [RQ7] Faster bank sets period
    assign aFast = effA <= effC;
    assign fastRatio = aFast ? effA : effC;
    assign slowRatio = aFast ? effC : effA;
    assign slowCount = aFast ? countC : countA;
    assign fastWrap = aFast ? wrapA : wrapC;
    assign slowNext = (boundary || (slowCount == slowRatio - W'(1))) ? '0 : slowCount + W'(1);
    // [RQ8] Lead test for any ratio pair
    assign leadHit = (slowRatio - slowNext) == fastRatio;

    // [RQ6] Low for one fast period
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            pulseLow <= 1'b0;
        else if (clkEn)
        begin
            if (holdReset)
                pulseLow <= 1'b0;
            else if (fastWrap)
                pulseLow <= leadHit;
        end
    end

    // ------------------------------------------------------------
    // Serial freeze receiver
    // ------------------------------------------------------------
    zdb_pkg::zdb_rx_state_t rxState;
    logic sClkPrev, sRise;
    logic [3:0] bitCount;
    // [RQ10] Twelve freeze enables
    logic [zdb_pkg::FREEZE_BITS-1:0] shiftReg, freezeBits;

    // [RQ16] Rising serial clock edge
    assign sRise = serClk && !sClkPrev;

    // [RQ14] Start bit then twelve bits
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rxState <= zdb_pkg::RX_IDLE;
            sClkPrev <= 1'b0;
            bitCount <= '0;
            shiftReg <= '0;
        end
        else if (clkEn)
        begin
            sClkPrev <= serClk;
            if (holdReset)
                rxState <= zdb_pkg::RX_IDLE;
            else
            begin
                case (rxState)
                    zdb_pkg::RX_IDLE:
                    begin
                        bitCount <= '0;
                        if (sRise && !serData)
                            rxState <= zdb_pkg::RX_SHIFT;
                    end
                    zdb_pkg::RX_SHIFT:
                    begin
                        if (sRise)
                        begin
                            shiftReg <= {serData, shiftReg[zdb_pkg::FREEZE_BITS-1:1]};
                            bitCount <= bitCount + 4'h1;
                            if (bitCount == zdb_pkg::LAST_BIT)
                                rxState <= zdb_pkg::RX_COMMIT;
                        end
                    end
                    default:
                        rxState <= zdb_pkg::RX_IDLE;
                endcase
            end
        end
    end

    // [RQ21] Commit whole frame
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            freezeBits <= zdb_pkg::FREEZE_RESET;
        else if (clkEn)
        begin
            // [RQ22] All outputs run after reset
            if (holdReset)
                freezeBits <= zdb_pkg::FREEZE_RESET;
            else if (rxState == zdb_pkg::RX_COMMIT)
                freezeBits <= shiftReg;
        end
    end

    // ------------------------------------------------------------
    // Freeze enables, taken at period boundaries
    // ------------------------------------------------------------
    logic [3:0] enA, enB;
    logic [3:1] enC;
    logic enPulse;

    // [RQ13] Enables move at boundaries
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            enA <= '1;
            enB <= '1;
            enC <= '1;
            enPulse <= 1'b1;
        end
        else if (clkEn)
        begin
            if (holdReset)
            begin
                enA <= '1;
                enB <= '1;
                enC <= '1;
                enPulse <= 1'b1;
            end
            else
            begin
                // [RQ17] Bit to output mapping
                if (wrapA)
                    enA <= freezeBits[zdb_pkg::FRZ_A_LSB +: 4];
                if (wrapB)
                    enB <= freezeBits[zdb_pkg::FRZ_B_LSB +: 4];
                if (wrapC)
                    enC <= freezeBits[zdb_pkg::FRZ_C_LSB +: 3];
                if (fastWrap && !leadHit)
                    enPulse <= freezeBits[zdb_pkg::FRZ_PULSE];
            end
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bank_a_clock_outputs <= '0;
            bank_b_clock_outputs <= '0;
            bank_c_clock_outputs <= '0;
            feedback_clock_out <= 1'b0;
            coincidencePulse_n <= 1'b0;
            outputsEnabled <= 1'b0;
        end
        else if (clkEn)
        begin
            outputsEnabled <= !holdReset;
            if (holdReset)
            begin
                bank_a_clock_outputs <= '0;
                bank_b_clock_outputs <= '0;
                bank_c_clock_outputs <= '0;
                feedback_clock_out <= 1'b0;
                coincidencePulse_n <= 1'b0;
            end
            else
            begin
                // [RQ12] Zero stops, one runs
                bank_a_clock_outputs <= {4{levelA}} & enA;
                bank_b_clock_outputs <= {4{levelB}} & enB;
                // [RQ4] Upper bank C inversion
                bank_c_clock_outputs <= {{2{levelC ^ invert}}, levelC, levelC} & {enC, 1'b1};
                // [RQ11] Feedback never frozen
                feedback_clock_out <= levelFb;
                // [RQ9] Frozen pulse held low
                coincidencePulse_n <= enPulse && !pulseLow;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_ratio_a;
        boundary && !holdReset && codeA == 2'h3 |=> ratioA == 4'hC;
    endproperty
    a_ratio_a: assert property (p_ratio_a) // [RQ1]
        else $error("bank A ratio not twelve");

    property p_ratio_c;
        boundary && !holdReset && codeC == 2'h0 |=> ratioC == 4'h8;
    endproperty
    a_ratio_c: assert property (p_ratio_c) // [RQ2]
        else $error("bank C ratio not eight");

    property p_halve;
        !halveActive && tick && !boundary && !holdReset |=> !tick;
    endproperty
    a_halve: assert property (p_halve) // [RQ3]
        else $error("halving stage ticked twice");

    property p_invert;
        clkEn && !holdReset && enC[3] |=> bank_c_clock_outputs[3] == ($past(levelC) ^ $past(invert));
    endproperty
    a_invert: assert property (p_invert) // [RQ4]
        else $error("bank C upper output inversion wrong");

    property p_no_runt;
        !holdReset && $changed(ratioA) |-> countA == 4'h0;
    endproperty
    a_no_runt: assert property (p_no_runt) // [RQ5]
        else $error("ratio changed mid period");

    property p_pulse_start;
        $rose(pulseLow) |-> (countA == 4'h0 || countC == 4'h0);
    endproperty
    a_pulse_start: assert property (p_pulse_start) // [RQ6]
        else $error("pulse started off a period edge");

    property p_frozen_low;
        clkEn && !enA[0] |=> !bank_a_clock_outputs[0];
    endproperty
    a_frozen_low: assert property (p_frozen_low) // [RQ9]
        else $error("frozen output not low");

    property p_freeze_edge;
        !holdReset && $changed(enA) |-> countA == 4'h0;
    endproperty
    a_freeze_edge: assert property (p_freeze_edge) // [RQ13]
        else $error("bank A freeze moved mid period");

    property p_c0_free;
        clkEn && !holdReset |=> bank_c_clock_outputs[0] == $past(levelC);
    endproperty
    a_c0_free: assert property (p_c0_free) // [RQ11]
        else $error("bank C output 0 frozen");

    property p_commit;
        !holdReset && $changed(freezeBits) |-> $past(rxState) == zdb_pkg::RX_COMMIT;
    endproperty
    a_commit: assert property (p_commit) // [RQ21]
        else $error("freeze bits applied mid frame");

    property p_reset_out;
        clkEn && holdReset |=> !outputsEnabled && bank_a_clock_outputs == 4'h0;
    endproperty
    a_reset_out: assert property (p_reset_out) // [RQ18]
        else $error("outputs live during master reset");

    c_boundary: cover property (boundary && nextA != ratioA);
    c_pulse: cover property ($fell(coincidencePulse_n));
    c_commit: cover property (rxState == zdb_pkg::RX_COMMIT);

endmodule

`default_nettype wire

// ===== zdb_ctrl_model.sv
// Board controller model: free running serial freeze port
`timescale 1ns/1ps
`default_nettype none
module zdb_ctrl_model (
    input wire logic ref_clk,
    output logic serial_freeze_clock,
    output logic serial_freeze_data
);
    logic [2:0] ph = 3'h0;
    logic dataBit = 1'h1;
    assign serial_freeze_data = dataBit;
    // Free running clock, four low four high
    assign serial_freeze_clock = ph[2];
    always @(posedge ref_clk)
    begin
        ph <= ph + 3'h1;
    end
    // Start bit then twelve bits, one clock each
    task automatic frame(input logic [11:0] bits);
        @(negedge serial_freeze_clock);
        dataBit <= 1'h0;
        for (int i = 0; i < 12; i++)
        begin
            @(negedge serial_freeze_clock);
            dataBit <= bits[i];
        end
        @(negedge serial_freeze_clock);
        dataBit <= 1'h1;
    endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the output generator
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic mrOe = 1'h1;
    logic pllUse = 1'h1;
    logic srcSel = 1'h1;
    logic tref1 = 1'h0;
    logic tref2 = 1'h0;
    logic pick = 1'h0;
    logic halve = 1'h1;
    logic inv = 1'h0;
    logic [1:0] codeA = 2'h0;
    logic [1:0] codeB = 2'h0;
    logic [1:0] codeC = 2'h0;
    logic serClk;
    logic serData;
    logic [3:0] bankA;
    logic [3:0] bankB;
    logic [3:0] bankC;
    logic fbOut;
    logic pulse_n;
    logic outEn;
    logic [14:0] outs;
    logic [13:0] acc;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    int p;
    int t0;
    int old;
    int nw;
    int ra[4] = '{2, 6, 4, 12};
    int rb[4] = '{2, 6, 4, 10};
    int rc[4] = '{8, 2, 6, 4};
    int pa[4] = '{0, 3, 1, 3};
    int pc[4] = '{0, 1, 0, 3};
    int pf[4] = '{2, 2, 6, 4};
    logic [11:0] fr[2] = '{12'h5A5, 12'h000};
    logic [13:0] fx[2] = '{14'h1BA5, 14'h1100};
    assign outs = {~pulse_n, pulse_n, fbOut, bankC, bankB, bankA};
    always #5 ref_clk = ~ref_clk;
    zdb_ctrl_model zdb_ctrl_model_i (
        .ref_clk(ref_clk),
        .serial_freeze_clock(serClk),
        .serial_freeze_data(serData)
    );
    zdb_output_gen zdb_output_gen_i (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clkEn(1'h1),
        .master_reset_output_enable(mrOe),
        .pll_use(pllUse),
        .primary_source_select(srcSel),
        .primary_reference(1'h0),
        .first_test_reference(tref1),
        .second_test_reference(tref2),
        .test_clock_pick(pick),
        .vco_halve_select(halve),
        .bank_a_ratio_select(codeA),
        .bank_b_ratio_select(codeB),
        .bank_c_ratio_select(codeC),
        .feedback_ratio_select(3'h0),
        .bank_c_upper_invert(inv),
        .serial_freeze_clock(serClk),
        .serial_freeze_data(serData),
        .bank_a_clock_outputs(bankA),
        .bank_b_clock_outputs(bankB),
        .bank_c_clock_outputs(bankC),
        .feedback_clock_out(fbOut),
        .coincidencePulse_n(pulse_n),
        .outputsEnabled(outEn)
    );
    // ----
    // Helpers
    // ----
    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        tref1 <= ~tref1;
        if (cyc % 2 == 1)
            tref2 <= ~tref2;
        if (cyc == 60000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic rise(input int k);
        logic pv;
        pv = outs[k];
        tick(1);
        while (!(outs[k] && !pv))
        begin
            pv = outs[k];
            tick(1);
        end
    endtask
    task automatic per(input int k);
        rise(k);
        t0 = cyc;
        rise(k);
        p = cyc - t0;
    endtask
    task automatic orw(input int n);
        acc = '0;
        repeat (n)
        begin
            tick(1);
            acc |= outs[13:0];
        end
    endtask
    task automatic setsel(input int h, input int a, input int b, input int c);
        @(posedge ref_clk);
        halve <= 1'(h);
        codeA <= 2'(a);
        codeB <= 2'(b);
        codeC <= 2'(c);
    endtask
    // ----
    // Tests
    // ----
    initial
    begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'h1;
        tick(10);
        orw(20);
        chk(acc, 14'h3FFF);
        for (int h = 1; h >= 0; h--)
            for (int i = 0; i < 4; i++)
            begin
                old = ra[codeA] * (2 - int'(halve));
                nw = ra[i] * (2 - h);
                setsel(h, i, i, i);
                repeat (60)
                begin
                    per(0);
                    chk(p >= (old < nw ? old : nw) && p <= (old > nw ? old : nw), 1);
                end
                tick(600);
                per(0);
                chk(p, nw);
                per(4);
                chk(p, rb[i] * (2 - h));
                per(8);
                chk(p, rc[i] * (2 - h));
                per(12);
                chk(p, 4 * (2 - h));
            end
        for (int i = 0; i < 4; i++)
        begin
            setsel(1, pa[i], 0, pc[i]);
            tick(600);
            rise(14);
            t0 = cyc;
            rise(13);
            chk(cyc - t0, pf[i]);
            chk({bankA[0], bankC[0]}, 2'h3);
        end
        setsel(1, 0, 0, 0);
        @(posedge ref_clk);
        inv <= 1'h1;
        tick(700);
        repeat (16)
        begin
            chk({bankC[3], bankC[2]}, {~bankC[1], ~bankC[1]});
            tick(1);
        end
        @(posedge ref_clk);
        inv <= 1'h0;
        tick(5);
        chk({bankC[3], bankC[2]}, {bankC[1], bankC[1]});
        for (int f = 0; f < 2; f++)
        begin
            zdb_ctrl_model_i.frame(fr[f]);
            tick(40);
            orw(20);
            chk(acc, fx[f]);
        end
        @(posedge ref_clk);
        mrOe <= 1'h0;
        tick(5);
        chk({outEn, outs[13:0]}, 15'h0000);
        @(posedge ref_clk);
        mrOe <= 1'h1;
        tick(5);
        chk(outEn, 1'h1);
        orw(20);
        chk(acc, 14'h3FFF);
        @(posedge ref_clk);
        pllUse <= 1'h0;
        srcSel <= 1'h0;
        pick <= 1'h1;
        tick(100);
        per(0);
        chk(p, 8);
        @(posedge ref_clk);
        pick <= 1'h0;
        tick(100);
        per(0);
        chk(p, 4);
        wrap_up();
    end
endmodule
`default_nettype wire
